// ===== core/lsa_core.sv
// Single data transfer execution core with APB register access
// Behaviour
// - run only when condition field passes
// - address is base plus or minus offset
// - offset: 12-bit immediate or shifted register
// - bit 23 set adds, clear subtracts
// - bit 24 selects pre or post indexing
// - pre-indexed writes back only when bit 21
// - post-indexed always writes back base
// - post-indexed with bit 21 is non-privileged
// - bit 22 selects byte, else word
// - register shift amounts are not supported
// - byte order input picks lane mapping
// - little-endian byte lanes rise with address
// - byte load zero-extends into transfer register
// - byte store replicates low byte four times
// - misaligned word load rotates the little-endian addressed byte low, whatever the byte order input
// - word store drives register unchanged
// - big-endian byte lanes fall with address
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
module lsa_core import lsa_pkg::*; (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic byte_order_select,
	input logic [31:0] mem_rdata,
	input logic mem_ack,
	output lsa_mem_req_t mem_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	lsa_state_t s;
	lsa_state_t next_s;

	logic busy;
	logic cond_ok;
	logic wr_access;
	logic rd_setup;
	logic [31:0] imm_off;
	logic [31:0] shifted_off;
	logic [31:0] off_val;
	logic [31:0] sum;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic [1:0] lane;
	logic [1:0] lane_sel;
	logic [31:0] lane_shift;
	logic [31:0] load_val;
	logic is_pre;
	logic do_wb;

	assign busy = (s.phase != LSA_IDLE);
	assign wr_access = psel & penable & pwrite;
	assign rd_setup = psel & !penable & !pwrite;
	assign is_pre = s.instr[LSA_BIT_BEFORE];

	// ----------------------------------------
	// Address generation
	// ----------------------------------------
	// condition gate
	assign cond_ok = lsa_cond_pass(s.instr[31:LSA_COND_LSB], s.nzcv);

	assign imm_off = {20'h0, s.instr[LSA_IMM_WIDTH-1:0]};

	lsa_offset_shift u_shift (
		.value(s.offs),
		.ctrl(s.instr[LSA_SHIFT_CTRL_LSB+7:LSA_SHIFT_CTRL_LSB]),
		.carry_in(s.nzcv[1]),
		.result(shifted_off)
	);

	assign off_val = s.instr[LSA_BIT_OFFSET_SORT] ? shifted_off : imm_off;
	assign sum = s.instr[LSA_BIT_ADD_OFFSET] ? (s.base + off_val) : (s.base - off_val);
	assign do_wb = !is_pre | s.instr[LSA_BIT_BASE_UPDATE];

	// ----------------------------------------
	// Load data lanes
	// ----------------------------------------
	assign lane = s.mem.addr[1:0];
	assign lane_sel = byte_order_select ? ~lane : lane;
	assign lane_shift = mem_rdata >> {lane_sel, 3'b000};
	assign load_val = s.mem.byte_sel ? {24'h0, lane_shift[7:0]} :
		lsa_rotr(mem_rdata, {lane, 3'b000});

	// ----------------------------------------
	// Register readback
	// ----------------------------------------
	assign status_word = {26'h0, s.bad_form, s.mem.user, s.wrote_back, s.skipped, s.done, busy};

	always_comb begin
		case (paddr)
			LSA_OFF_INSTR: read_word = s.instr;
			LSA_OFF_BASE: read_word = s.base;
			LSA_OFF_OFFSET: read_word = s.offs;
			LSA_OFF_XFER: read_word = s.xfer;
			LSA_OFF_CTRL: read_word = {24'h0, s.nzcv, 2'h0, s.priv, 1'b0};
			LSA_OFF_STATUS: read_word = status_word;
			LSA_OFF_ADDR: read_word = s.mem.addr;
			LSA_OFF_NEWBASE: read_word = s.newbase;
			default: read_word = 32'h0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// Read data is captured in setup so the access phase needs no wait
		if (rd_setup) begin
			next_s.rdata = lsa_reg_hit(paddr) ? read_word : 32'h0;
		end
		// Operands are frozen while busy so the address stays coherent
		if (wr_access && !busy && lsa_reg_hit(paddr)) begin
			case (paddr)
				LSA_OFF_INSTR: next_s.instr = pwdata;
				LSA_OFF_BASE: next_s.base = pwdata;
				LSA_OFF_OFFSET: next_s.offs = pwdata;
				LSA_OFF_XFER: next_s.xfer = pwdata;
				LSA_OFF_CTRL: begin
					next_s.priv = pwdata[LSA_CTRL_PRIV];
					next_s.nzcv = pwdata[LSA_CTRL_NZCV_LSB+3:LSA_CTRL_NZCV_LSB];
					if (pwdata[LSA_CTRL_GO]) begin
						next_s.phase = LSA_EVAL;
						next_s.done = 1'b0;
						next_s.skipped = 1'b0;
						next_s.wrote_back = 1'b0;
						next_s.bad_form = 1'b0;
						next_s.mem.user = 1'b0;
					end
				end
				default: next_s.phase = s.phase;
			endcase
		end
		case (s.phase)
			LSA_EVAL: begin
				if (!cond_ok) begin
					next_s.skipped = 1'b1;
					next_s.done = 1'b1;
					next_s.phase = LSA_IDLE;
				end else if (s.instr[LSA_BIT_OFFSET_SORT] && s.instr[LSA_BIT_REG_AMOUNT]) begin
					next_s.bad_form = 1'b1;
					next_s.done = 1'b1;
					next_s.phase = LSA_IDLE;
				end else begin
					next_s.newbase = sum;
					next_s.mem.addr = is_pre ? sum : s.base;
					next_s.mem.req = 1'b1;
					next_s.mem.write = !s.instr[LSA_BIT_READ_DIR];
					next_s.mem.byte_sel = s.instr[LSA_BIT_NARROW];
					next_s.mem.user = !s.priv | (!is_pre & s.instr[LSA_BIT_BASE_UPDATE]);
					next_s.mem.wdata = s.instr[LSA_BIT_NARROW] ? {4{s.xfer[7:0]}} : s.xfer;
					next_s.phase = LSA_MEM;
				end
			end
			LSA_MEM: begin
				if (mem_ack) begin
					next_s.mem.req = 1'b0;
					if (!s.mem.write) begin
						next_s.xfer = load_val;
					end
					if (do_wb) begin
						next_s.base = s.newbase;
					end
					next_s.wrote_back = do_wb;
					next_s.done = 1'b1;
					next_s.phase = LSA_IDLE;
				end
			end
			default: next_s.phase = next_s.phase;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= LSA_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & !lsa_reg_hit(paddr);
	assign mem_out = s.mem;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [31:0] off_seen;
	logic [7:0] le_byte;
	logic [7:0] be_byte;

	// offset as seen from the two bases
	assign off_seen = s.instr[LSA_BIT_ADD_OFFSET] ? (s.newbase - s.base) : (s.base - s.newbase);

	// lanes picked one by one, apart from the shifter
	always_comb begin
		case (s.mem.addr[1:0])
			2'h1: {be_byte, le_byte} = {mem_rdata[23:16], mem_rdata[15:8]};
			2'h2: {be_byte, le_byte} = {mem_rdata[15:8], mem_rdata[23:16]};
			2'h3: {be_byte, le_byte} = {mem_rdata[7:0], mem_rdata[31:24]};
			default: {be_byte, le_byte} = {mem_rdata[31:24], mem_rdata[7:0]};
		endcase
	end

	cond_skip_a: assert property ((s.phase == LSA_EVAL) && !cond_ok |=>
		(s.phase == LSA_IDLE) && s.skipped && s.done && !s.mem.req)
		else $error("failed condition still started a transfer");

	addr_sel_a: assert property ((s.phase == LSA_MEM) |->
		s.mem.addr == (is_pre ? sum : s.base))
		else $error("transfer address does not follow indexing");

	up_down_a: assert property ((s.phase == LSA_MEM) |->
		s.newbase == (s.instr[LSA_BIT_ADD_OFFSET] ? s.base + off_val : s.base - off_val))
		else $error("modified base has wrong sign of offset");

	post_wb_a: assert property ((s.phase == LSA_MEM) && mem_ack && !is_pre |=>
		(s.base == $past(s.newbase)) && s.wrote_back)
		else $error("post-indexed transfer did not write back");

	pre_keep_a: assert property ((s.phase == LSA_MEM) && mem_ack && is_pre &&
		!s.instr[LSA_BIT_BASE_UPDATE] |=> $stable(s.base) && !s.wrote_back)
		else $error("pre-indexed transfer changed base without flag");

	user_force_a: assert property ((s.phase == LSA_MEM) && !is_pre &&
		s.instr[LSA_BIT_BASE_UPDATE] |-> mem_out.user)
		else $error("post-indexed forced access not marked non-privileged");

	byte_store_a: assert property (mem_out.req && mem_out.write && mem_out.byte_sel |->
		mem_out.wdata == {4{s.xfer[7:0]}})
		else $error("byte store not replicated on all lanes");

	word_store_a: assert property (mem_out.req && mem_out.write && !mem_out.byte_sel |->
		mem_out.wdata == s.xfer)
		else $error("word store data altered");

	byte_load_a: assert property ((s.phase == LSA_MEM) && mem_ack && !s.mem.write &&
		s.mem.byte_sel |=> s.xfer[31:8] == 24'h0)
		else $error("byte load left upper bits set");

	bad_form_a: assert property ((s.phase == LSA_EVAL) && cond_ok &&
		s.instr[LSA_BIT_OFFSET_SORT] && s.instr[LSA_BIT_REG_AMOUNT] |=> !s.mem.req ##1 !s.mem.req)
		else $error("register-specified shift amount was executed");

	imm_off_a: assert property ((s.phase == LSA_MEM) && !s.instr[LSA_BIT_OFFSET_SORT] |->
		off_seen == {20'h0, s.instr[LSA_IMM_WIDTH-1:0]})
		else $error("immediate offset not taken from the low twelve bits");

	reg_lsl_a: assert property ((s.phase == LSA_MEM) && s.instr[LSA_BIT_OFFSET_SORT] &&
		(s.instr[6:5] == 2'h0) |-> off_seen == (s.offs << s.instr[11:7]))
		else $error("register offset not shifted left as encoded");

	dir_bit_a: assert property ((s.phase == LSA_MEM) |->
		mem_out.write == !s.instr[LSA_BIT_READ_DIR])
		else $error("transfer direction does not follow the load bit");

	width_bit_a: assert property ((s.phase == LSA_MEM) |->
		mem_out.byte_sel == s.instr[LSA_BIT_NARROW])
		else $error("transfer width does not follow the byte bit");

	req_hold_a: assert property (mem_out.req && !mem_ack |=>
		mem_out.req && $stable(mem_out))
		else $error("transfer request changed before its acknowledge");

	lane_little_a: assert property ((s.phase == LSA_MEM) && mem_ack && !s.mem.write &&
		s.mem.byte_sel && !byte_order_select |=> s.xfer == {24'h0, $past(le_byte)})
		else $error("little-endian byte load took the wrong lane");

	lane_big_a: assert property ((s.phase == LSA_MEM) && mem_ack && !s.mem.write &&
		s.mem.byte_sel && byte_order_select |=> s.xfer == {24'h0, $past(be_byte)})
		else $error("big-endian byte load took the wrong lane");

	word_rot_a: assert property ((s.phase == LSA_MEM) && mem_ack && !s.mem.write &&
		!s.mem.byte_sel && !byte_order_select |=> s.xfer[7:0] == $past(le_byte))
		else $error("misaligned word load did not rotate addressed byte low");

	finish_a: assert property ((s.phase == LSA_MEM) && mem_ack |=>
		(s.phase == LSA_IDLE) && s.done && !mem_out.req)
		else $error("acknowledged transfer did not complete");

endmodule : lsa_core

// ===== core/lsa_pkg.sv
// Package: constants, types and helpers of the load/store addressing block
package lsa_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] LSA_OFF_INSTR = 8'h00;
	localparam logic [7:0] LSA_OFF_BASE = 8'h04;
	localparam logic [7:0] LSA_OFF_OFFSET = 8'h08;
	localparam logic [7:0] LSA_OFF_XFER = 8'h0C;
	localparam logic [7:0] LSA_OFF_CTRL = 8'h10;
	localparam logic [7:0] LSA_OFF_STATUS = 8'h14;
	localparam logic [7:0] LSA_OFF_ADDR = 8'h18;
	localparam logic [7:0] LSA_OFF_NEWBASE = 8'h1C;

	// ----------------------------------------
	// Instruction field positions
	// ----------------------------------------
	localparam int LSA_COND_LSB = 28;
	localparam int LSA_BIT_OFFSET_SORT = 25;
	localparam int LSA_BIT_BEFORE = 24;
	localparam int LSA_BIT_ADD_OFFSET = 23;
	localparam int LSA_BIT_NARROW = 22;
	localparam int LSA_BIT_BASE_UPDATE = 21;
	localparam int LSA_BIT_READ_DIR = 20;
	localparam int LSA_BIT_REG_AMOUNT = 4;
	localparam int LSA_SHIFT_CTRL_LSB = 4;
	localparam int LSA_IMM_WIDTH = 12;

	// ----------------------------------------
	// Control and status bit positions
	// ----------------------------------------
	localparam int LSA_CTRL_GO = 0;
	localparam int LSA_CTRL_PRIV = 1;
	localparam int LSA_CTRL_NZCV_LSB = 4;
	localparam int LSA_STAT_BUSY = 0;
	localparam int LSA_STAT_DONE = 1;
	localparam int LSA_STAT_SKIPPED = 2;
	localparam int LSA_STAT_WROTE_BACK = 3;
	localparam int LSA_STAT_USER = 4;
	localparam int LSA_STAT_BAD_FORM = 5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {LSA_IDLE, LSA_EVAL, LSA_MEM} lsa_phase_t;

	typedef struct packed {
		logic req;
		logic write;
		logic byte_sel;
		logic user;
		logic [31:0] addr;
		logic [31:0] wdata;
	} lsa_mem_req_t;

	typedef struct packed {
		lsa_phase_t phase;
		logic [31:0] instr;
		logic [31:0] base;
		logic [31:0] offs;
		logic [31:0] xfer;
		logic [31:0] newbase;
		logic [31:0] rdata;
		logic priv;
		logic [3:0] nzcv;
		logic done;
		logic skipped;
		logic wrote_back;
		logic bad_form;
		lsa_mem_req_t mem;
	} lsa_state_t;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam lsa_state_t LSA_STATE_RST = '0;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lsa_rotr(input logic [31:0] d, input logic [4:0] n);
		return (d >> n) | (d << (6'd32 - {1'b0, n}));
	endfunction : lsa_rotr

	function automatic logic lsa_cond_pass(input logic [3:0] cond, input logic [3:0] nzcv);
		logic n;
		logic z;
		logic c;
		logic v;
		logic r;
		n = nzcv[3];
		z = nzcv[2];
		c = nzcv[1];
		v = nzcv[0];
		case (cond)
			4'h0: r = z;
			4'h1: r = !z;
			4'h2: r = c;
			4'h3: r = !c;
			4'h4: r = n;
			4'h5: r = !n;
			4'h6: r = v;
			4'h7: r = !v;
			4'h8: r = c & !z;
			4'h9: r = !c | z;
			4'hA: r = (n == v);
			4'hB: r = (n != v);
			4'hC: r = !z & (n == v);
			4'hD: r = z | (n != v);
			4'hE: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : lsa_cond_pass

	function automatic logic lsa_reg_hit(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= LSA_OFF_NEWBASE);
	endfunction : lsa_reg_hit

endpackage : lsa_pkg

// ===== core/lsa_offset_shift.sv
// Barrel shifter for the register form of the transfer offset
`timescale 1ns/1ns
module lsa_offset_shift import lsa_pkg::*; (
	input logic [31:0] value,
	input logic [7:0] ctrl,
	input logic carry_in,
	output logic [31:0] result
);

	logic [4:0] amount;
	logic [1:0] kind;

	assign amount = ctrl[7:3];
	assign kind = ctrl[2:1];

	// ----------------------------------------
	// Shift by immediate amount
	// ----------------------------------------
	// immediate shift control
	always_comb begin
		case (kind)
			2'h0: result = value << amount;
			// Amount zero encodes a full 32-place shift
			2'h1: result = (amount == 5'h0) ? 32'h0 : (value >> amount);
			2'h2: result = (amount == 5'h0) ? {32{value[31]}} :
				32'($signed(value) >>> amount);
			default: result = (amount == 5'h0) ? {carry_in, value[31:1]} :
				lsa_rotr(value, amount);
		endcase
	end

endmodule : lsa_offset_shift

// ===== verif/lsa_mem_model.sv
// Memory partner model on the data side of the transfer core
`timescale 1ns/1ns
module lsa_mem_model import lsa_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input lsa_mem_req_t mem_out,
	input wire logic [1:0] lat,
	input wire logic [31:0] rword,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [1:0] cnt;
	logic [31:0] mem;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			mem <= 32'h0;
		end else if (mem_out.req && !mem_ack && cnt == lat) begin
			mem_ack <= 1'b1;
			mem_rdata <= rword;
			if (mem_out.write && mem_out.byte_sel) begin
				mem[8*mem_out.addr[1:0] +: 8] <= mem_out.wdata[8*mem_out.addr[1:0] +: 8];
			end else if (mem_out.write) begin
				mem <= mem_out.wdata;
			end
		end else begin
			cnt <= (mem_out.req && !mem_ack) ? cnt + 2'h1 : 2'h0;
			mem_ack <= 1'b0;
			// Idle bus toggles so stale data never looks valid
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : lsa_mem_model

// ===== verif/load_store_addressing_test.sv
// Self-checking bench of the load/store addressing core
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t: got %h exp %h", $time, a, e); end end
module load_store_addressing_test import lsa_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, byte_order_select, mem_ack, chk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_rdata, rword, rd;
	logic [1:0] lat;
	lsa_mem_req_t mem_out;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	logic [64:0] qr[$];
	logic [66:0] qm[$];
	lsa_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.byte_order_select(byte_order_select), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.mem_out(mem_out));
	lsa_mem_model mm (.pclk(pclk), .presetn(presetn), .mem_out(mem_out), .lat(lat),
		.rword(rword), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ----
	// Monitor and timeout
	// ----
	always @(posedge pclk) begin : mon
		logic [64:0] e;
		logic [66:0] m;
		logic [66:0] g;
		cyc <= cyc + 1;
		if (psel && penable && pready && chk) begin
			e = qr.pop_front();
			`CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
		end
		if (mem_out.req && mem_ack) begin
			m = qm.pop_front();
			g = {mem_out.user, mem_out.write, mem_out.byte_sel, mem_out.addr, mem_out.wdata};
			g[31:0] = g[31:0] & {32{m[65]}};
			`CHK(g, m)
		end
		// Timeout last so nothing runs after the report
		if (cyc > 12000) begin
			n_mismatch++;
			final_report();
		end
	end
	// ----
	// Tasks
	// ----
	task final_report;
		if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic err);
		qr.push_back({err, m, e});
		chk <= 1'b1;
		apb(1'b0, a, 32'h0);
	endtask : rchk
	function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] & !f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = !f[2] & (f[3] == f[0]);
			default: r = 1'b1;
		endcase
		return r ^ c[0];
	endfunction : cpass
	task op(input logic [31:0] ins, b, o, x, input logic [7:0] ctl);
		logic [31:0] off, nb, ad, res, wd;
		logic [1:0] ln;
		logic [4:0] sa;
		logic ex, wb, bad, ld, pass, us;
		apb(1'b1, LSA_OFF_INSTR, ins);
		apb(1'b1, LSA_OFF_BASE, b);
		apb(1'b1, LSA_OFF_OFFSET, o);
		apb(1'b1, LSA_OFF_XFER, x);
		pass = cpass(ins[31:28], ctl[7:4]);
		bad = pass & ins[25] & ins[4];
		ex = pass & !bad;
		sa = ins[11:7];
		case (ins[6:5])
			2'h0: off = o << sa;
			2'h1: off = (sa == 5'h0) ? 32'h0 : o >> sa;
			2'h2: off = (sa == 5'h0) ? {32{o[31]}} : 32'($signed(o) >>> sa);
			default: off = (sa == 5'h0) ? {ctl[5], o[31:1]} : 32'({o, o} >> sa);
		endcase
		if (!ins[25]) off = {20'h0, ins[11:0]};
		// add or subtract, pre or post
		nb = ins[23] ? b + off : b - off;
		ad = ins[24] ? nb : b;
		wb = ex & (!ins[24] | ins[21]);
		ld = ins[20];
		ln = ad[1:0] ^ {2{byte_order_select}};
		res = ins[22] ? {24'h0, rword[8*ln +: 8]} : 32'({rword, rword} >> {ad[1:0], 3'h0});
		wd = ins[22] ? {4{x[7:0]}} : x;
		us = !ctl[1] | (!ins[24] & ins[21]);
		if (ex) qm.push_back({us, !ld, ins[22], ad, ld ? 32'h0 : wd});
		apb(1'b1, LSA_OFF_CTRL, {24'h0, ctl[7:1], 1'b1});
		rd = 32'h0;
		repeat (40) if (!rd[1]) apb(1'b0, LSA_OFF_STATUS, 32'h0);
		rchk(LSA_OFF_STATUS, '1, {26'h0, bad, ex & us, wb, !pass, 2'h2}, 1'b0);
		rchk(LSA_OFF_BASE, '1, wb ? nb : b, 1'b0);
		rchk(LSA_OFF_XFER, '1, (ex & ld) ? res : x, 1'b0);
		rchk(LSA_OFF_CTRL, '1, {24'h0, ctl[7:4], 2'h0, ctl[1], 1'b0}, 1'b0);
		if (ex) rchk(LSA_OFF_ADDR, '1, ad, 1'b0);
		if (ex) rchk(LSA_OFF_NEWBASE, '1, nb, 1'b0);
	endtask : op
	// ----
	// Main sequence
	// ----
	initial begin
		logic [31:0] ins;
		void'($urandom(14));
		{presetn, psel, penable, pwrite, chk, byte_order_select} = '0;
		{paddr, pwdata, rword, lat} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(LSA_OFF_STATUS, '1, 32'h0, 1'b0);
		rchk(8'h20, '1, 32'h0, 1'b1);
		rchk(8'h05, '1, 32'h0, 1'b1);
		for (int i = 0; i < 96; i++) begin
			ins = $urandom;
			ins[31:26] = {i[3:0], 2'h1};
			if (ins[25]) ins[4] = 1'b0;
			lat <= 2'($urandom);
			rword <= $urandom;
			byte_order_select <= 1'($urandom);
			op(ins, $urandom, $urandom, $urandom, 8'($urandom) & 8'hF2);
		end
		op(32'hE6100010, 32'h100, 32'h4, 32'h55, 8'h02);
		final_report();
	end
endmodule : load_store_addressing_test
